// ==== shared/scsp_defs.svh ====
`ifndef SCSP_DEFS_SVH
`define SCSP_DEFS_SVH
// Reset value of the seven-bit slave address.
`define SCSP_DEV_ADDR_RST 7'h69
// Reset value of the register pointer.
`define SCSP_PTR_RST 8'h00
// Bits per byte on the wire and the index of the last transmitted bit.
`define SCSP_BYTE_BITS 4'h8
`define SCSP_TX_LAST 4'h7
// Locations that hold real configuration registers.
`define SCSP_CFG0_LO 8'h08
`define SCSP_CFG0_HI 8'h1b
`define SCSP_CFG1_LO 8'h40
`define SCSP_CFG1_HI 8'h57
`define SCSP_CFG1_BASE 6'h14
`define SCSP_CFG_BYTES 44
// Reset value of every configuration register.
`define SCSP_CFG_RST 8'h00
// Depth of the write FIFO.
`define SCSP_FIFO_DEPTH 4
`endif

// ==== shared/scsp_pkg.sv ====
package scsp_pkg;
`include "scsp_defs.svh"

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADR, ST_ACKDEV, ST_RXREG, ST_RXDAT, ST_ACKW, ST_TX, ST_MACK
  } scsp_st_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } scsp_cfg_wr_t;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    scsp_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic mack_ok;
    logic sda_oe;
    logic sda_out;
    logic out_v;
    scsp_cfg_wr_t out;
    logic [`SCSP_CFG_BYTES-1:0][7:0] cfg;
  } scsp_state_t;
endpackage

// ==== hw/scsp_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Filling side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two.");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } scsp_fifo_state_t;

  scsp_fifo_state_t q;
  scsp_fifo_state_t d;
  logic push;
  logic pop;

  assign in_ready_o = (q.cnt != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ==== hw/scsp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scsp_defs.svh"
// Function
// - Acknowledge each burst-write byte the FIFO can take and keep accepting until the master stops.
// - Advance the register pointer by one after each data byte the FIFO accepts.
// - Pointer holds one past the last location written or read.
// - On own address with read direction, acknowledge then send the pointed byte.
// - Master ends a read with no acknowledge then stop; data drive ceases.
// - Address-only write frame loads the pointer and stores nothing.
// - Pointer advances after each sent byte; master acknowledge sends the next byte.
// - Every location in the eight-bit space is readable.
// - Pointer increment from the top location wraps to zero.
// - First byte after start is address plus direction; answer only on match.
// - Pull the data line low on the ninth clock of a matching address byte and of every later written byte, except a data byte that finds the FIFO full.
module scsp_top
  import scsp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `SCSP_DEV_ADDR_RST,
  parameter int FIFO_DEPTH = `SCSP_FIFO_DEPTH
) (
  // Clock, reset and enable.
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // Two-wire serial link.
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // Configuration write stream.
  output logic CFG_WR_VALID_O,
  output scsp_cfg_wr_t CFG_WR_O,
  input wire logic CFG_WR_READY_I
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("FIFO_DEPTH must be at least two.");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decoding.

  function automatic logic [6:0] cfg_map(input logic [7:0] a);
    logic [7:0] off;
    off = 8'h00;
    if (a >= `SCSP_CFG0_LO && a <= `SCSP_CFG0_HI) begin
      off = a - `SCSP_CFG0_LO;
      return {1'b1, off[5:0]};
    end else if (a >= `SCSP_CFG1_LO && a <= `SCSP_CFG1_HI) begin
      off = a - `SCSP_CFG1_LO;
      return {1'b1, off[5:0] + `SCSP_CFG1_BASE};
    end
    return 7'h00;
  endfunction

  scsp_state_t q;
  scsp_state_t d;
  logic scl;
  logic scl_p;
  logic sda;
  logic sda_p;
  logic ev_start;
  logic ev_stop;
  logic ev_rise;
  logic ev_fall;
  logic [6:0] rd_map;
  logic [7:0] rd_byte;
  logic [6:0] wr_map;
  logic fifo_in_v;
  logic fifo_in_rdy;
  logic fifo_out_v;
  logic fifo_out_rdy;
  scsp_cfg_wr_t fifo_in;
  scsp_cfg_wr_t fifo_out;

  // Only the second and third stages are read; the first may be metastable.
  assign scl = q.scl_sync[1];
  assign scl_p = q.scl_sync[2];
  assign sda = q.sda_sync[1];
  assign sda_p = q.sda_sync[2];
  assign ev_start = scl & scl_p & sda_p & ~sda;
  assign ev_stop = scl & scl_p & ~sda_p & sda;
  assign ev_rise = scl & ~scl_p;
  assign ev_fall = ~scl & scl_p;

  // Unmapped locations read as zero.
  assign rd_map = cfg_map(q.ptr);
  assign rd_byte = rd_map[6] ? q.cfg[rd_map[5:0]] : 8'h00;
  assign fifo_in = '{addr: q.ptr, data: q.shreg};
  assign fifo_out_rdy = ~q.out_v | CFG_WR_READY_I;
  assign wr_map = cfg_map(fifo_out.addr);

  ////////////////////////////////////////////////////////////////////////////////
  // Write FIFO.  A full FIFO makes the byte go unacknowledged, since the
  // link has no clock stretching to hold the master off.

  scsp_fifo #(.W($bits(scsp_cfg_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .in_valid_i(fifo_in_v),
    .in_ready_o(fifo_in_rdy),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_out_v),
    .out_ready_i(fifo_out_rdy),
    .out_data_o(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    d = q;
    fifo_in_v = 1'b0;
    d.scl_sync = {q.scl_sync[1:0], SCL_I};
    d.sda_sync = {q.sda_sync[1:0], SDA_I};
    if (ev_start) begin
      d.st = ST_DEVADR;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (ev_stop) begin
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        ST_DEVADR, ST_RXREG, ST_RXDAT: begin
          if (ev_rise && q.bitcnt < `SCSP_BYTE_BITS) begin
            d.shreg = {q.shreg[6:0], sda};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (ev_fall && q.bitcnt == `SCSP_BYTE_BITS) begin
            d.bitcnt = 4'h0;
            if (q.st == ST_DEVADR) begin
              if (q.shreg[7:1] == DEV_ADDR) begin
                d.st = ST_ACKDEV;
                d.rw = q.shreg[0];
                d.sda_oe = 1'b1;
              end else begin
                d.st = ST_IDLE;
              end
            end else if (q.st == ST_RXREG) begin
              d.ptr = q.shreg;
              d.sda_oe = 1'b1;
              d.st = ST_ACKW;
            end else begin
              fifo_in_v = 1'b1;
              d.st = ST_ACKW;
              if (fifo_in_rdy) begin
                d.ptr = q.ptr + 8'h01;
                d.sda_oe = 1'b1;
              end
            end
          end
        end
        ST_ACKW: begin
          if (ev_fall) begin
            d.sda_oe = 1'b0;
            d.st = ST_RXDAT;
          end
        end
        ST_ACKDEV: begin
          if (ev_fall) begin
            if (q.rw) begin
              d.shreg = rd_byte;
              d.sda_oe = ~rd_byte[7];
              d.st = ST_TX;
            end else begin
              d.sda_oe = 1'b0;
              d.st = ST_RXREG;
            end
          end
        end
        ST_TX: begin
          if (ev_fall) begin
            if (q.bitcnt == `SCSP_TX_LAST) begin
              d.sda_oe = 1'b0;
              d.ptr = q.ptr + 8'h01;
              d.bitcnt = 4'h0;
              d.mack_ok = 1'b0;
              d.st = ST_MACK;
            end else begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.sda_oe = ~q.shreg[6];
              d.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (ev_rise) begin
            d.mack_ok = ~sda;
          end else if (ev_fall) begin
            if (q.mack_ok) begin
              d.shreg = rd_byte;
              d.sda_oe = ~rd_byte[7];
              d.st = ST_TX;
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
        default: begin
          d.sda_oe = 1'b0;
        end
      endcase
    end
    if (q.out_v && CFG_WR_READY_I) begin
      d.out_v = 1'b0;
    end
    if (fifo_out_v && fifo_out_rdy) begin
      d.out_v = 1'b1;
      d.out = fifo_out;
      if (wr_map[6]) begin
        d.cfg[wr_map[5:0]] = fifo_out.data;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.scl_sync <= 3'h7;
      q.sda_sync <= 3'h7;
      q.st <= ST_IDLE;
      q.ptr <= `SCSP_PTR_RST;
      q.cfg <= {`SCSP_CFG_BYTES{`SCSP_CFG_RST}};
    end else if (CE_I) begin
      q <= d;
    end
  end

  assign SDA_O = q.sda_out;
  assign SDA_OE_O = q.sda_oe;
  assign CFG_WR_VALID_O = q.out_v;
  assign CFG_WR_O = q.out;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_byte_end(scsp_st_t s);
    CE_I && !ev_start && !ev_stop && q.st == s && ev_fall && q.bitcnt == `SCSP_BYTE_BITS;
  endsequence

  burst_ack_a: assert property (s_byte_end(ST_RXDAT) ##0 fifo_in_rdy |=> q.sda_oe && q.st == ST_ACKW)
    else $error("Burst data byte not acknowledged.");
  ptr_step_a: assert property (s_byte_end(ST_RXDAT) ##0 fifo_in_rdy |=> q.ptr == $past(q.ptr) + 8'h01)
    else $error("Pointer did not advance after a data byte.");
  read_ack_a: assert property (s_byte_end(ST_DEVADR) ##0 q.shreg == {DEV_ADDR, 1'b1}
                               |=> q.sda_oe && q.rw && q.st == ST_ACKDEV)
    else $error("Own read address not acknowledged.");
  foreign_addr_a: assert property (s_byte_end(ST_DEVADR) ##0 q.shreg[7:1] != DEV_ADDR
                                   |=> !q.sda_oe && q.st == ST_IDLE)
    else $error("Answered a foreign address.");
  stop_release_a: assert property (CE_I && ev_stop |=> !q.sda_oe && q.st == ST_IDLE)
    else $error("Data line still driven after stop.");
  reg_addr_a: assert property (s_byte_end(ST_RXREG) |-> !fifo_in_v ##1 q.ptr == $past(q.shreg))
    else $error("Register address frame mishandled.");
  rd_ptr_a: assert property (CE_I && !ev_start && !ev_stop && q.st == ST_TX && ev_fall
                             && q.bitcnt == `SCSP_TX_LAST |=> q.ptr == $past(q.ptr) + 8'h01)
    else $error("Pointer did not advance after a read byte.");
  seq_read_a: assert property (CE_I && !ev_start && !ev_stop && q.st == ST_MACK && ev_fall
                               && q.mack_ok |=> q.st == ST_TX && q.shreg == $past(rd_byte))
    else $error("Sequential read did not continue.");
  // The ranges are spelled out here so that a fault in the decoder cannot hide itself.
  unmapped_zero_a: assert property (q.ptr < `SCSP_CFG0_LO || q.ptr > `SCSP_CFG1_HI
                                    || (q.ptr > `SCSP_CFG0_HI && q.ptr < `SCSP_CFG1_LO)
                                    |-> rd_byte == 8'h00)
    else $error("Unmapped location did not read zero.");
  oe_slot_a: assert property (q.sda_oe |-> !q.sda_out
                              && (q.st == ST_ACKDEV || q.st == ST_ACKW || q.st == ST_TX))
    else $error("Data line driven outside an own slot.");
endmodule
`default_nettype wire

// ==== verif/scsp_mst.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsp_mst (
  // Clock.
  input wire logic clk_i,
  // Two-wire link, open drain on the data line.
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Data only moves while the clock is low, so no bit can fake a start or stop.
  task automatic bit_x(input logic b, output logic r);
    cyc(2);
    sda_oe_o <= ~b;
    cyc(6);
    scl_o <= 1'b1;
    cyc(7);
    r = sda_i;
    cyc(1);
    scl_o <= 1'b0;
  endtask
  task automatic start();
    cyc(2);
    sda_oe_o <= 1'b0;
    cyc(6);
    scl_o <= 1'b1;
    cyc(150);
    sda_oe_o <= 1'b1;
    cyc(150);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    cyc(2);
    sda_oe_o <= 1'b1;
    cyc(6);
    scl_o <= 1'b1;
    cyc(150);
    sda_oe_o <= 1'b0;
    cyc(325);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask
endmodule
`default_nettype wire

// ==== verif/scsp_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsp_top_tb_top
  import scsp_pkg::*;
;
  localparam logic [6:0] ADR = 7'h69;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ready = 1'b1;
  logic ce = 1'b1;
  logic scl;
  logic mst_oe;
  logic sda_oe_d;
  logic sda_d;
  logic valid;
  logic sda_w;
  scsp_cfg_wr_t wr;
  scsp_cfg_wr_t q[$];
  int n_fail = 0;
  int num_checks = 0;
  // The line is pulled up, so whoever releases it leaves a one.
  assign sda_w = ~(sda_oe_d | mst_oe);
  always #2 clk = ~clk;
  scsp_top #(.DEV_ADDR(ADR), .FIFO_DEPTH(4)) i_dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SCL_I(scl), .SDA_I(sda_w),
    .SDA_O(sda_d), .SDA_OE_O(sda_oe_d), .CFG_WR_VALID_O(valid), .CFG_WR_O(wr),
    .CFG_WR_READY_I(ready));
  scsp_mst i_mst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(mst_oe));
  always @(posedge clk) begin
    if (valid === 1'b1 && ready === 1'b1 && ce === 1'b1) begin
      q.push_back(wr);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_q(input logic [7:0] a0, input logic [7:0] d0, input int n);
    scsp_cfg_wr_t e;
    i_mst.cyc(40);
    chk(16'(q.size()), 16'(n));
    for (int i = 0; i < n && q.size() > 0; i++) begin
      e = q.pop_front();
      chk(e, {a0 + 8'(i), d0 + 8'(i)});
    end
    q.delete();
  endtask
  task automatic wr_frame(input logic [7:0] ra, input logic [7:0] d0, input int n,
                          output int n_ack);
    logic a;
    n_ack = 0;
    i_mst.start();
    i_mst.wbyte({ADR, 1'b0}, a);
    chk(16'(a), 16'h1);
    i_mst.wbyte(ra, a);
    chk(16'(a), 16'h1);
    for (int i = 0; i < n; i++) begin
      i_mst.wbyte(d0 + 8'(i), a);
      n_ack += int'(a);
    end
    i_mst.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_burst();
    int n;
    wr_frame(8'h1a, 8'ha1, 3, n);
    chk(16'(n), 16'h3);
    chk_q(8'h1a, 8'ha1, 3);
    $display("test burst done");
  endtask
  task automatic t_rand();
    logic a;
    logic [7:0] d;
    i_mst.start();
    i_mst.wbyte({ADR, 1'b0}, a);
    i_mst.wbyte(8'h1a, a);
    i_mst.start();
    i_mst.wbyte({ADR, 1'b1}, a);
    chk(16'(a), 16'h1);
    i_mst.rbyte(1'b0, d);
    chk(16'(d), 16'h00a1);
    i_mst.stop();
    chk_q(8'h00, 8'h00, 0);
    $display("test random read done");
  endtask
  task automatic t_cur();
    logic a;
    logic [7:0] d;
    i_mst.start();
    i_mst.wbyte({ADR, 1'b1}, a);
    chk(16'(a), 16'h1);
    i_mst.rbyte(1'b1, d);
    chk(16'(d), 16'h00a2);
    i_mst.rbyte(1'b0, d);
    chk(16'(d), 16'h0000);
    i_mst.stop();
    chk({14'h0, sda_oe_d, sda_d}, 16'h0);
    $display("test current read done");
  endtask
  task automatic t_wrap();
    int n;
    wr_frame(8'hff, 8'h11, 2, n);
    chk(16'(n), 16'h2);
    chk_q(8'hff, 8'h11, 2);
    $display("test wrap done");
  endtask
  task automatic t_foreign();
    logic a;
    i_mst.start();
    i_mst.wbyte({7'h50, 1'b0}, a);
    chk(16'(a), 16'h0);
    i_mst.wbyte(8'h08, a);
    chk(16'(a), 16'h0);
    i_mst.stop();
    chk_q(8'h00, 8'h00, 0);
    $display("test foreign address done");
  endtask
  // A stalled stream must end in a refusal, and nothing accepted may be lost.
  task automatic t_full();
    int n;
    @(posedge clk);
    ready <= 1'b0;
    wr_frame(8'h08, 8'h30, 6, n);
    // Four buffered words plus the one held in the output register are taken.
    chk(16'(n), 16'h5);
    @(posedge clk);
    ce <= 1'b0;
    ready <= 1'b1;
    i_mst.cyc(10);
    // With the enable low nothing may leave, even though the consumer is ready.
    chk({15'h0, valid}, 16'h1);
    ce <= 1'b1;
    chk_q(8'h08, 8'h30, n);
    $display("test full buffer done");
  endtask
  // A reset in mid-run must clear the stored configuration and release the line.
  task automatic t_reset();
    logic a;
    logic [7:0] d;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    chk({14'h0, sda_oe_d, valid}, 16'h0);
    rst_n <= 1'b1;
    i_mst.cyc(3);
    i_mst.start();
    i_mst.wbyte({ADR, 1'b0}, a);
    i_mst.wbyte(8'h08, a);
    i_mst.start();
    i_mst.wbyte({ADR, 1'b1}, a);
    chk(16'(a), 16'h1);
    i_mst.rbyte(1'b0, d);
    chk(16'(d), 16'h0000);
    i_mst.stop();
    $display("test reset done");
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_burst();
    t_rand();
    t_cur();
    t_wrap();
    t_foreign();
    t_full();
    t_reset();
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
